// [srmm_map.svh]
// Behaviour
// - 8-bit status register: hold result in upper nibble, setup result in lower.
// - setup detector reports reference level in the interval before the capture edge.
// - hold detector reports reference level in the interval after the capture edge.
// - hold 0 with setup 1..7 flags a possible setup error.
// - setup 8 with hold 0..8 means no error, best hold margin.
// - hold 8 with setup 9..15 means no error, best combined margin.
// - hold 8 with setup 0 means no error, best setup margin.
// - hold 9..15 with setup 0 flags a possible hold error.
// - both nibbles zero flags a possible setup or hold error.
// - each sample leaves after a fixed clock count for a given configuration.
// - total latency is filter latency plus framing latency.
// - framing latency ignores real or complex output type.
// - filter latency 31 full band, 90 real dcm1/complex dcm2, 102 complex dcm3.
// - filter latency 162 real dcm2/complex dcm4, 292 real dcm4, 1594 deepest.
// - full band framing latency 82, 44, 25 at ratios 1/8, 1/4, 1/2.
// - dcm4 framing latency 315, 164, 88 at ratios 1/8, 1/4, 1/2.
// - ratio is converters divided by lanes.
// - unsupported mode and ratio pairs are not offered.
// - dcm5 only with real output; framing latency 62 at ratio 1.
// - dcm15, 16, 30, 40, 48 only with complex output.
// - reference pulse must last at least two sample clocks.
`ifndef SRMM_MAP_SVH
`define SRMM_MAP_SVH

`define SRMM_OFF_CFG 12'h100
`define SRMM_OFF_LAT 12'h104
`define SRMM_OFF_PART 12'h108
`define SRMM_OFF_STAT 12'h128
`define SRMM_OFF_VERD 12'h12c

`define SRMM_CFG_MODE 4:0
`define SRMM_CFG_CPLX 8
`define SRMM_CFG_CONV 19:16
`define SRMM_CFG_LANES 27:24
`define SRMM_VERD_RUNT 8

`define SRMM_RST_MODE 5'h00
`define SRMM_RST_CONV 4'h1
`define SRMM_RST_LANES 4'h1

`define SRMM_HOLD_LAST 4'he
`define SRMM_RATIO_BIAS 4'h3
`define SRMM_FILL_MAX 11'h7ff

// filter latency rows {real, complex}; zero marks a type not offered
`define SRMM_FLT_FULL {11'h01f, 11'h000}
`define SRMM_FLT_DCM1 {11'h05a, 11'h000}
`define SRMM_FLT_DCM2 {11'h0a2, 11'h05a}
`define SRMM_FLT_DCM3 {11'h0d4, 11'h066}
`define SRMM_FLT_DCM4 {11'h124, 11'h0a2}
`define SRMM_FLT_DCM5 {11'h17c, 11'h000}
`define SRMM_FLT_DCM6 {11'h1a8, 11'h0d4}
`define SRMM_FLT_DCM8 {11'h228, 11'h124}
`define SRMM_FLT_DCM10 {11'h2b6, 11'h17c}
`define SRMM_FLT_DCM12 {11'h32e, 11'h1a8}
`define SRMM_FLT_DCM15 {11'h000, 11'h1f4}
`define SRMM_FLT_DCM16 {11'h000, 11'h228}
`define SRMM_FLT_DCM20 {11'h58c, 11'h2b6}
`define SRMM_FLT_DCM24 {11'h63a, 11'h32e}
`define SRMM_FLT_DCM30 {11'h000, 11'h344}
`define SRMM_FLT_DCM40 {11'h000, 11'h58c}
`define SRMM_FLT_DCM48 {11'h000, 11'h63a}

// framing latency rows, ratio 8 first down to ratio 1/8; zero marks not offered
`define SRMM_FRM_FULL {9'h003, 9'h009, 9'h007, 9'h00e, 9'h019, 9'h02c, 9'h052}
`define SRMM_FRM_DCM1 {9'h000, 9'h000, 9'h007, 9'h00e, 9'h019, 9'h02c, 9'h052}
`define SRMM_FRM_DCM2 {9'h000, 9'h007, 9'h00e, 9'h01b, 9'h02e, 9'h054, 9'h0a0}
`define SRMM_FRM_DCM3 {9'h000, 9'h00b, 9'h015, 9'h027, 9'h043, 9'h07c, 9'h0ed}
`define SRMM_FRM_DCM4 {9'h009, 9'h00e, 9'h01b, 9'h032, 9'h058, 9'h0a4, 9'h13b}
`define SRMM_FRM_DCM5 {9'h000, 9'h000, 9'h02b, 9'h03e, 9'h06d, 9'h0cb, 9'h000}
`define SRMM_FRM_DCM6 {9'h00e, 9'h015, 9'h027, 9'h049, 9'h082, 9'h0f3, 9'h000}
`define SRMM_FRM_DCM8 {9'h012, 9'h01b, 9'h032, 9'h060, 9'h0ac, 9'h143, 9'h000}
`define SRMM_FRM_DCM10 {9'h016, 9'h021, 9'h03e, 9'h077, 9'h0d5, 9'h000, 9'h000}
`define SRMM_FRM_DCM12 {9'h01b, 9'h027, 9'h049, 9'h08e, 9'h0ff, 9'h000, 9'h000}
`define SRMM_FRM_DCM15 {9'h021, 9'h02f, 9'h05a, 9'h0b0, 9'h13e, 9'h000, 9'h000}
`define SRMM_FRM_DCM16 {9'h023, 9'h032, 9'h060, 9'h0bc, 9'h153, 9'h000, 9'h000}
`define SRMM_FRM_DCM20 {9'h02b, 9'h03e, 9'h077, 9'h0e9, 9'h000, 9'h000, 9'h000}
`define SRMM_FRM_DCM24 {9'h033, 9'h049, 9'h08e, 9'h117, 9'h000, 9'h000, 9'h000}
`define SRMM_FRM_DCM30 {9'h03e, 9'h05a, 9'h0b0, 9'h15c, 9'h000, 9'h000, 9'h000}
`define SRMM_FRM_DCM40 {9'h052, 9'h077, 9'h0e9, 9'h000, 9'h000, 9'h000, 9'h000}
`define SRMM_FRM_DCM48 {9'h061, 9'h08e, 9'h117, 9'h000, 9'h000, 9'h000, 9'h000}

`endif

// [srmm_pkg.sv]
`default_nettype none
package srmm_pkg;
	typedef enum logic [4:0] {
		DCM_FULL = 5'h00, DCM_1 = 5'h01, DCM_2 = 5'h02, DCM_3 = 5'h03, DCM_4 = 5'h04,
		DCM_5 = 5'h05, DCM_6 = 5'h06, DCM_8 = 5'h07, DCM_10 = 5'h08, DCM_12 = 5'h09,
		DCM_15 = 5'h0a, DCM_16 = 5'h0b, DCM_20 = 5'h0c, DCM_24 = 5'h0d, DCM_30 = 5'h0e,
		DCM_40 = 5'h0f, DCM_48 = 5'h10
	} srmm_dcm_t;

	typedef enum logic [2:0] {
		VERD_NONE = 3'h0, VERD_SETUP_ERR = 3'h1, VERD_OK_HOLD = 3'h2, VERD_OK_BOTH = 3'h3,
		VERD_OK_SETUP = 3'h4, VERD_HOLD_ERR = 3'h5, VERD_EITHER = 3'h6
	} srmm_verd_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_HOLD = 2'b10
	} srmm_st_t;

	typedef struct packed {
		logic [3:0] lanes;
		logic [3:0] conv;
		logic cplx;
		logic [4:0] decimation_ratio_mode;
	} srmm_cfg_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} srmm_sample_t;

	typedef struct packed {
		srmm_st_t st;
		logic sync1;
		logic sync2;
		logic [15:0] hist;
		logic [3:0] cnt;
		logic [3:0] hacc;
		logic [3:0] setup;
		logic [7:0] status;
		srmm_verd_t verd;
		logic runt;
		srmm_cfg_t cfg;
		logic [10:0] filt;
		logic [8:0] fram;
		logic [10:0] lat;
		logic sup;
		logic [10:0] wptr;
		logic [10:0] fill;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		srmm_sample_t sout;
	} srmm_state_t;
endpackage : srmm_pkg
`default_nettype wire

// [srmm_top.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "srmm_map.svh"
module srmm_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// system reference pin
	input wire logic sysref_i,
	// sample stream
	input wire srmm_pkg::srmm_sample_t sample_i,
	output srmm_pkg::srmm_sample_t sample_o
);
	srmm_pkg::srmm_state_t s_q;
	srmm_pkg::srmm_state_t s_d;
	srmm_pkg::srmm_sample_t mem [0:2047];
	srmm_pkg::srmm_sample_t rd_w;
	logic edge_w;
	logic hold_done_w;
	logic [3:0] setup_w;
	logic [3:0] hold_w;
	logic [21:0] flt_row_w;
	logic [62:0] frm_row_w;
	logic [10:0] filt_w;
	logic [8:0] fram_w;
	logic [2:0] m_log_w;
	logic [2:0] l_log_w;
	logic [3:0] ridx_w;
	logic setup_ph_w;
	logic wr_acc_w;
	logic rd_ok_w;
	logic [10:0] rd_addr_w;

	function automatic logic [3:0] zeros15(input logic [14:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 15; i++) begin
			n = n + {3'h0, ~b[i]};
		end
		return n;
	endfunction : zeros15

	// {ok, log2}; only power-of-two counts up to eight are valid
	function automatic logic [2:0] log2c(input logic [3:0] v);
		unique case (v)
			4'h1: log2c = 3'h4;
			4'h2: log2c = 3'h5;
			4'h4: log2c = 3'h6;
			4'h8: log2c = 3'h7;
			default: log2c = 3'h0;
		endcase
	endfunction : log2c

	function automatic srmm_pkg::srmm_verd_t classify(input logic [3:0] h, input logic [3:0] su);
		if (h == 4'h0 && su == 4'h0) begin
			classify = srmm_pkg::VERD_EITHER;
		end else if (h == 4'h0 && su <= 4'h7) begin
			classify = srmm_pkg::VERD_SETUP_ERR;
		end else if (su == 4'h8 && h <= 4'h8) begin
			classify = srmm_pkg::VERD_OK_HOLD;
		end else if (h == 4'h8 && su >= 4'h9) begin
			classify = srmm_pkg::VERD_OK_BOTH;
		end else if (h == 4'h8 && su == 4'h0) begin
			classify = srmm_pkg::VERD_OK_SETUP;
		end else if (h >= 4'h9 && su == 4'h0) begin
			classify = srmm_pkg::VERD_HOLD_ERR;
		end else begin
			classify = srmm_pkg::VERD_NONE;
		end
	endfunction : classify

	// latency tables, keyed on mode only so output type cannot alter framing
	always_comb begin
		unique case (s_q.cfg.decimation_ratio_mode)
			srmm_pkg::DCM_FULL: flt_row_w = `SRMM_FLT_FULL;
			srmm_pkg::DCM_1: flt_row_w = `SRMM_FLT_DCM1;
			srmm_pkg::DCM_2: flt_row_w = `SRMM_FLT_DCM2;
			srmm_pkg::DCM_3: flt_row_w = `SRMM_FLT_DCM3;
			srmm_pkg::DCM_4: flt_row_w = `SRMM_FLT_DCM4;
			srmm_pkg::DCM_5: flt_row_w = `SRMM_FLT_DCM5;
			srmm_pkg::DCM_6: flt_row_w = `SRMM_FLT_DCM6;
			srmm_pkg::DCM_8: flt_row_w = `SRMM_FLT_DCM8;
			srmm_pkg::DCM_10: flt_row_w = `SRMM_FLT_DCM10;
			srmm_pkg::DCM_12: flt_row_w = `SRMM_FLT_DCM12;
			srmm_pkg::DCM_15: flt_row_w = `SRMM_FLT_DCM15;
			srmm_pkg::DCM_16: flt_row_w = `SRMM_FLT_DCM16;
			srmm_pkg::DCM_20: flt_row_w = `SRMM_FLT_DCM20;
			srmm_pkg::DCM_24: flt_row_w = `SRMM_FLT_DCM24;
			srmm_pkg::DCM_30: flt_row_w = `SRMM_FLT_DCM30;
			srmm_pkg::DCM_40: flt_row_w = `SRMM_FLT_DCM40;
			srmm_pkg::DCM_48: flt_row_w = `SRMM_FLT_DCM48;
			default: flt_row_w = '0;
		endcase
		unique case (s_q.cfg.decimation_ratio_mode)
			srmm_pkg::DCM_FULL: frm_row_w = `SRMM_FRM_FULL;
			srmm_pkg::DCM_1: frm_row_w = `SRMM_FRM_DCM1;
			srmm_pkg::DCM_2: frm_row_w = `SRMM_FRM_DCM2;
			srmm_pkg::DCM_3: frm_row_w = `SRMM_FRM_DCM3;
			srmm_pkg::DCM_4: frm_row_w = `SRMM_FRM_DCM4;
			srmm_pkg::DCM_5: frm_row_w = `SRMM_FRM_DCM5;
			srmm_pkg::DCM_6: frm_row_w = `SRMM_FRM_DCM6;
			srmm_pkg::DCM_8: frm_row_w = `SRMM_FRM_DCM8;
			srmm_pkg::DCM_10: frm_row_w = `SRMM_FRM_DCM10;
			srmm_pkg::DCM_12: frm_row_w = `SRMM_FRM_DCM12;
			srmm_pkg::DCM_15: frm_row_w = `SRMM_FRM_DCM15;
			srmm_pkg::DCM_16: frm_row_w = `SRMM_FRM_DCM16;
			srmm_pkg::DCM_20: frm_row_w = `SRMM_FRM_DCM20;
			srmm_pkg::DCM_24: frm_row_w = `SRMM_FRM_DCM24;
			srmm_pkg::DCM_30: frm_row_w = `SRMM_FRM_DCM30;
			srmm_pkg::DCM_40: frm_row_w = `SRMM_FRM_DCM40;
			srmm_pkg::DCM_48: frm_row_w = `SRMM_FRM_DCM48;
			default: frm_row_w = '0;
		endcase
	end

	assign m_log_w = log2c(s_q.cfg.conv);
	assign l_log_w = log2c(s_q.cfg.lanes);
	// ratio index 0..6 stands for converters/lanes of 1/8..8
	assign ridx_w = 4'(m_log_w[1:0]) + `SRMM_RATIO_BIAS - 4'(l_log_w[1:0]);
	assign filt_w = s_q.cfg.cplx ? flt_row_w[10:0] : flt_row_w[21:11];
	assign fram_w = frm_row_w[9 * ridx_w[2:0] +: 9];

	assign edge_w = s_q.sync2 & ~s_q.hist[0];
	// the sample just before the edge is low by definition, so it is skipped
	assign setup_w = zeros15(s_q.hist[15:1]);
	assign hold_w = s_q.hacc + 4'(s_q.sync2);
	assign hold_done_w = (s_q.st == srmm_pkg::ST_HOLD) && (s_q.cnt == `SRMM_HOLD_LAST);

	assign setup_ph_w = psel_i & ~penable_i;
	assign wr_acc_w = psel_i & penable_i & s_q.pready & pwrite_i;

	assign rd_addr_w = s_q.wptr - (s_q.lat - 11'h001);
	assign rd_w = mem[rd_addr_w];
	assign rd_ok_w = s_q.sup && (s_q.fill >= s_q.lat);

	always_comb begin
		s_d = s_q;
		s_d.sync1 = sysref_i;
		s_d.sync2 = s_q.sync1;
		s_d.hist = {s_q.hist[14:0], s_q.sync2};

		unique case (s_q.st)
			srmm_pkg::ST_IDLE: begin
				if (edge_w) begin
					s_d.st = srmm_pkg::ST_HOLD;
					s_d.setup = setup_w;
					s_d.cnt = 4'h0;
					s_d.hacc = 4'h0;
				end
			end
			srmm_pkg::ST_HOLD: begin
				s_d.cnt = s_q.cnt + 4'h1;
				s_d.hacc = hold_w;
				if (hold_done_w) begin
					s_d.st = srmm_pkg::ST_IDLE;
					s_d.status = {hold_w, s_q.setup};
					s_d.verd = classify(hold_w, s_q.setup);
				end
			end
		endcase

		// pulse of one clock seen right after the edge; set beats a same-cycle clear
		if (wr_acc_w && paddr_i == `SRMM_OFF_VERD && pwdata_i[`SRMM_VERD_RUNT]) begin
			s_d.runt = 1'b0;
		end
		if (s_q.st == srmm_pkg::ST_HOLD && s_q.cnt == 4'h0 && !s_q.sync2) begin
			s_d.runt = 1'b1;
		end

		s_d.filt = filt_w;
		s_d.fram = fram_w;
		s_d.lat = 11'(filt_w + 11'(fram_w));
		s_d.sup = m_log_w[2] & l_log_w[2] & (filt_w != 11'h000) & (fram_w != 9'h000);

		// fixed delay line: write index leads read index by one less than the total latency
		s_d.wptr = s_q.wptr + 11'h001;
		if (s_q.fill != `SRMM_FILL_MAX) begin
			s_d.fill = s_q.fill + 11'h001;
		end
		s_d.sout.valid = rd_ok_w & rd_w.valid;
		s_d.sout.data = rd_ok_w ? rd_w.data : 16'h0000;

		// registers are written only at the completing access edge
		if (wr_acc_w && paddr_i == `SRMM_OFF_CFG) begin
			s_d.cfg.decimation_ratio_mode = pwdata_i[`SRMM_CFG_MODE];
			s_d.cfg.cplx = pwdata_i[`SRMM_CFG_CPLX];
			s_d.cfg.conv = pwdata_i[`SRMM_CFG_CONV];
			s_d.cfg.lanes = pwdata_i[`SRMM_CFG_LANES];
			s_d.fill = 11'h000;
		end

		// no wait state; the answer is registered in the setup phase, so the lines come straight from flops
		s_d.pready = setup_ph_w;
		s_d.pslverr = 1'b0;
		s_d.prdata = 32'h0000_0000;
		if (setup_ph_w) begin
			unique case (paddr_i)
				`SRMM_OFF_CFG: s_d.prdata = {4'h0, s_q.cfg.lanes, 4'h0, s_q.cfg.conv, 7'h00,
					s_q.cfg.cplx, 3'h0, s_q.cfg.decimation_ratio_mode};
				`SRMM_OFF_LAT: s_d.prdata = {s_q.sup, 20'h00000, s_q.lat};
				`SRMM_OFF_PART: s_d.prdata = {7'h00, s_q.fram, 5'h00, s_q.filt};
				`SRMM_OFF_STAT: s_d.prdata = {24'h000000, s_q.status};
				`SRMM_OFF_VERD: s_d.prdata = {23'h000000, s_q.runt, 5'h00, s_q.verd};
				default: s_d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
			s_q.st <= srmm_pkg::ST_IDLE;
			s_q.cfg.decimation_ratio_mode <= `SRMM_RST_MODE;
			s_q.cfg.conv <= `SRMM_RST_CONV;
			s_q.cfg.lanes <= `SRMM_RST_LANES;
		end else begin
			s_q <= s_d;
		end
	end

	// storage left unreset; reads are masked until the line has filled
	always_ff @(posedge mclk_i) begin
		mem[s_q.wptr] <= sample_i;
	end

	assign prdata_o = s_q.prdata;
	assign pready_o = s_q.pready;
	assign pslverr_o = s_q.pslverr;
	assign sample_o = s_q.sout;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	sequence s_capture;
		(s_q.st == srmm_pkg::ST_IDLE) && edge_w;
	endsequence

	sequence s_short_pulse;
		s_capture ##1 !s_q.sync2;
	endsequence

	AST_SETUP_LATCH: assert property (s_capture |-> ##16 (s_q.status[3:0] == $past(setup_w, 16)))
		else $error("setup nibble not taken from the capture edge");
	AST_STATUS_RO: assert property ((s_q.st == srmm_pkg::ST_IDLE) ##1 (s_q.st == srmm_pkg::ST_IDLE)
		|-> $stable(s_q.status))
		else $error("status changed without a capture");
	AST_RUNT_FLAG: assert property (s_short_pulse |-> ##[1:2] s_q.runt)
		else $error("short reference pulse not flagged");
	AST_EITHER: assert property (s_q.status == 8'h00 && s_q.st == srmm_pkg::ST_IDLE && $past(hold_done_w)
		|-> s_q.verd == srmm_pkg::VERD_EITHER)
		else $error("zero status not reported as either error");
	AST_HOLD_ERR: assert property ($rose(hold_done_w) ##1 (s_q.status[7:4] >= 4'h9 && s_q.status[3:0] == 4'h0)
		|-> s_q.verd == srmm_pkg::VERD_HOLD_ERR)
		else $error("hold error not classified");
	AST_LAT_SUM: assert property (s_q.sup |-> s_q.lat == 11'(s_q.filt + 11'(s_q.fram)))
		else $error("total latency is not the sum of its parts");
	AST_FULL_BAND: assert property (s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_FULL && !s_q.cfg.cplx
		&& s_q.cfg.conv == 4'h2 && s_q.cfg.lanes == 4'h8 |=> s_q.lat == 11'h04b)
		else $error("full band latency at ratio 1/4 wrong");
	AST_DCM4_HALF: assert property (s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_4 && s_q.cfg.cplx
		&& s_q.cfg.conv == 4'h2 && s_q.cfg.lanes == 4'h4 |=> s_q.lat == 11'h0fa)
		else $error("dcm4 latency at ratio 1/2 wrong");
	AST_DCM1_CUT: assert property (s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_1
		&& (s_q.cfg.conv == 4'h8 || s_q.cfg.conv == 4'h4) && s_q.cfg.lanes == 4'h1 |=> !s_q.sup)
		else $error("dcm1 offered at ratio 4 or 8");
	AST_CPLX_ONLY: assert property ((s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_15
		|| s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_16
		|| s_q.cfg.decimation_ratio_mode == srmm_pkg::DCM_48) && !s_q.cfg.cplx
		|=> !s_q.sup)
		else $error("complex-only mode offered as real");
	AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o || (psel_i && !penable_i))
		else $error("apb answer not one cycle after setup");
endmodule : srmm_top
`default_nettype wire

// [srmm_ref_src.sv]
`timescale 1ns/1ns
`default_nettype none
module srmm_ref_src (
	// clock
	input wire logic mclk_i,
	// reference pin
	output logic sysref_o
);
	initial sysref_o = 1'b0;

	// long high, low gap of g, pulse of w, then quiet low long enough for the hold window
	task automatic frame(input int g, input int w);
		@(posedge mclk_i);
		sysref_o <= 1'b1;
		repeat (20) @(posedge mclk_i);
		sysref_o <= 1'b0;
		repeat (g) @(posedge mclk_i);
		sysref_o <= 1'b1;
		repeat (w) @(posedge mclk_i);
		sysref_o <= 1'b0;
		repeat (30) @(posedge mclk_i);
	endtask : frame
endmodule : srmm_ref_src
`default_nettype wire

// [sysref_margin_monitor_latency_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "srmm_map.svh"
module sysref_margin_monitor_latency_tb;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic sysref_i;
	srmm_pkg::srmm_sample_t sample_i = '0;
	srmm_pkg::srmm_sample_t sample_o;
	srmm_pkg::srmm_sample_t hist [4096];
	int num_errors = 0;
	int tests_run = 0;
	int seed = 61311;
	int cyc = 0;
	int lat_chk = 0;
	logic [31:0] rd;
	logic err;
	logic [34:0] vt [15];
	int sg [8] = '{1, 9, 21, 11, 1, 5, 1, 9};
	int sw [8] = '{9, 9, 9, 9, 12, 1, 1, 3};

	always #5 mclk_i = ~mclk_i;

	srmm_top uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .sysref_i(sysref_i),
		.sample_i(sample_i), .sample_o(sample_o));
	srmm_ref_src ref_src (.mclk_i(mclk_i), .sysref_o(sysref_i));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		n = 0;
		// answer lines are looked at off the edge, where they have settled
		@(negedge mclk_i);
		while (pready_o !== 1'b1 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		if (pready_o !== 1'b1) begin
			chk("pready", 32'h1, 32'h0);
			end_of_test();
		end
		rd = prdata_o;
		err = pslverr_o;
		@(posedge mclk_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	// expected sample is what went in exactly lat_chk cycles earlier
	always @(posedge mclk_i) begin
		hist[cyc % 4096] = sample_i;
		sample_i <= 17'($random(seed));
		cyc++;
	end

	// compared off the edge so the launching edge cannot race the look
	always @(negedge mclk_i) begin
		if (lat_chk > 0) chk("sample_o", {15'h0, hist[(cyc - lat_chk) % 4096]}, {15'h0, sample_o});
	end

	task automatic stream(input int l);
		repeat (l + 4) @(posedge mclk_i);
		@(negedge mclk_i) lat_chk = l;
		repeat (40) @(posedge mclk_i);
		@(negedge mclk_i) lat_chk = 0;
	endtask : stream

	function automatic logic [31:0] lat_word(input logic [34:0] v);
		lat_word = {v[0], 20'h00000, v[0] ? 11'(v[20:10] + v[9:1]) : 11'h000};
	endfunction : lat_word

	function automatic logic [31:0] stat_exp(input int g, input int w);
		stat_exp = {24'h0, 4'(w > 16 ? 15 : w - 1), 4'(g > 16 ? 15 : g - 1)};
	endfunction : stat_exp

	function automatic logic [31:0] verd_exp(input logic [7:0] st, input int w);
		logic [3:0] h;
		logic [3:0] s;
		logic [2:0] v;
		h = st[7:4];
		s = st[3:0];
		if (h == 4'h0 && s == 4'h0) v = 3'h6;
		else if (h == 4'h0 && s <= 4'h7) v = 3'h1;
		else if (s == 4'h8 && h <= 4'h8) v = 3'h2;
		else if (h == 4'h8 && s >= 4'h9) v = 3'h3;
		else if (h == 4'h8 && s == 4'h0) v = 3'h4;
		else if (h >= 4'h9 && s == 4'h0) v = 3'h5;
		else v = 3'h0;
		verd_exp = {23'h0, w == 1, 5'h00, v};
	endfunction : verd_exp

	initial begin
		// mode, complex, converters, lanes, filter, framing, supported
		vt[0] = {5'h00, 1'h0, 4'h2, 4'h8, 11'h01f, 9'h02c, 1'h1};
		vt[1] = {5'h00, 1'h0, 4'h1, 4'h2, 11'h01f, 9'h019, 1'h1};
		vt[2] = {5'h04, 1'h1, 4'h2, 4'h4, 11'h0a2, 9'h058, 1'h1};
		vt[3] = {5'h04, 1'h0, 4'h1, 4'h8, 11'h124, 9'h13b, 1'h1};
		vt[4] = {5'h01, 1'h0, 4'h4, 4'h1, 11'h000, 9'h000, 1'h0};
		vt[5] = {5'h01, 1'h0, 4'h1, 4'h1, 11'h05a, 9'h00e, 1'h1};
		vt[6] = {5'h02, 1'h1, 4'h1, 4'h1, 11'h05a, 9'h01b, 1'h1};
		vt[7] = {5'h02, 1'h0, 4'h1, 4'h1, 11'h0a2, 9'h01b, 1'h1};
		vt[8] = {5'h03, 1'h1, 4'h1, 4'h1, 11'h066, 9'h027, 1'h1};
		vt[9] = {5'h05, 1'h0, 4'h1, 4'h1, 11'h17c, 9'h03e, 1'h1};
		vt[10] = {5'h05, 1'h1, 4'h1, 4'h1, 11'h000, 9'h000, 1'h0};
		vt[11] = {5'h0a, 1'h0, 4'h1, 4'h1, 11'h000, 9'h000, 1'h0};
		vt[12] = {5'h10, 1'h1, 4'h8, 4'h1, 11'h63a, 9'h061, 1'h1};
		vt[13] = {5'h10, 1'h0, 4'h8, 4'h1, 11'h000, 9'h000, 1'h0};
		vt[14] = {5'h00, 1'h0, 4'h3, 4'h1, 11'h000, 9'h000, 1'h0};
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		apb(1'b0, `SRMM_OFF_CFG, 32'h0);
		chk("cfg", 32'h01010000, rd);
		apb(1'b0, `SRMM_OFF_LAT, 32'h0);
		chk("lat", 32'h8000002d, rd);
		apb(1'b0, `SRMM_OFF_STAT, 32'h0);
		chk("stat", 32'h0, rd);
		chk("slverr", 32'h0, {31'h0, err});
		apb(1'b1, `SRMM_OFF_STAT, 32'hff);
		apb(1'b1, `SRMM_OFF_LAT, 32'h0);
		apb(1'b0, `SRMM_OFF_STAT, 32'h0);
		chk("stat", 32'h0, rd);
		apb(1'b0, `SRMM_OFF_LAT, 32'h0);
		chk("lat", 32'h8000002d, rd);
		apb(1'b0, 12'h200, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		stream(45);
		// hold in setup margin grows with the gap, hold count with the pulse width
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `SRMM_OFF_VERD, 32'h100);
			ref_src.frame(sg[i], sw[i]);
			apb(1'b0, `SRMM_OFF_STAT, 32'h0);
			chk("stat", stat_exp(sg[i], sw[i]), rd);
			apb(1'b0, `SRMM_OFF_VERD, 32'h0);
			chk("verd", verd_exp(stat_exp(sg[i], sw[i]), sw[i]), rd);
		end
		for (int i = 0; i < 15; i++) begin
			apb(1'b1, `SRMM_OFF_CFG, {4'h0, vt[i][24:21], 4'h0, vt[i][28:25], 7'h00, vt[i][29], 3'h0, vt[i][34:30]});
			apb(1'b0, `SRMM_OFF_LAT, 32'h0);
			chk("lat", lat_word(vt[i]), vt[i][0] ? rd : {rd[31], 31'h0});
			if (!vt[i][0]) begin
				repeat (3) @(negedge mclk_i);
				chk("valid", 32'h0, {31'h0, sample_o.valid});
			end
		end
		apb(1'b1, `SRMM_OFF_CFG, {4'h0, 4'h4, 4'h0, 4'h2, 7'h00, 1'b1, 3'h0, 5'h04});
		apb(1'b0, `SRMM_OFF_PART, 32'h0);
		chk("part", 32'h005800a2, rd);
		stream(250);
		end_of_test();
	end
endmodule : sysref_margin_monitor_latency_tb
`default_nettype wire
